// ---- tis_host_model.sv ----
// Host side model: decodes the serial interrupt lines.
// Assumes one level per IRQ number, synchronous to clk_sys.
`timescale 1ns/1ps
module tis_host_model (
    // Clock and reset
    input wire logic clk_sys,
    input wire logic rst,
    // Lines from the block
    input wire logic [15:0] irq_lines,
    // Decoded request, one edge behind
    output logic [3:0] irq_num,
    output logic irq_multi
);
    always_ff @(posedge clk_sys or posedge rst) begin
        if (rst) begin
            irq_num <= 4'h0;
            irq_multi <= 1'b0;
        end else begin
            irq_num <= 4'h0;
            for (int i = 0; i < 16; i++) if (irq_lines[i]) irq_num <= 4'(i);
            irq_multi <= ($countones(irq_lines) > 1);
        end
    end
endmodule // tis_host_model

// ---- tis_pkg.sv ----
// Package for the timer interrupt status and test block.
// Assumes a 32-bit AHB-Lite slave port with word-aligned registers.
package tis_pkg;

    // Register byte offsets
    localparam logic [7:0] TIS_OFS_STATUS_TEST = 8'h00;
    localparam logic [7:0] TIS_OFS_MASK_SELECT = 8'h04;

    // Status and test register fields
    localparam int TIS_BIT_FORCE_IRQ = 7;
    localparam int TIS_BIT_SELFTEST = 6;
    localparam int TIS_BIT_SW_IN_B = 5;
    localparam int TIS_BIT_SW_IN_A = 4;
    localparam int TIS_BIT_FLAG_C = 2;
    localparam int TIS_BIT_FLAG_B = 1;
    localparam int TIS_BIT_FLAG_A = 0;

    // Mask and select register fields
    localparam int TIS_BIT_GLOBAL_EN = 7;
    localparam int TIS_SEL_LSB = 4;
    localparam int TIS_BIT_MASK_C = 2;
    localparam int TIS_BIT_MASK_B = 1;
    localparam int TIS_BIT_MASK_A = 0;

    // Writable bits of each register
    localparam logic [7:0] TIS_TEST_WR_MASK = 8'hF0;
    localparam logic [7:0] TIS_MSEL_WR_MASK = 8'hF7;

    // Values after reset
    localparam logic [7:0] TIS_TEST_RESET = 8'h00;
    localparam logic [7:0] TIS_MSEL_RESET = 8'h00;
    localparam logic [2:0] TIS_FLAG_RESET = 3'h0;

    // AHB transfer type and response
    localparam logic [1:0] TIS_HTRANS_NONSEQ = 2'h2;
    localparam logic [1:0] TIS_HTRANS_SEQ = 2'h3;
    localparam logic TIS_HRESP_OKAY = 1'h0;

    // Line select code to serial interrupt number
    localparam logic [3:0] TIS_IRQ_MAP [8] = '{4'h3, 4'h4, 4'h5, 4'hA, 4'h6, 4'h7, 4'h9, 4'hB};

endpackage

// ---- tis_timer_irq.sv ----
// Timer interrupt status, test control and interrupt line routing.
// Assumes the counters' terminal count outputs and the pins are synchronous to clk_sys.
//
// Register access over AHB-Lite and the placing of the registers were decided locally.
`timescale 1ns/1ps

// What this block does
// - With the force-interrupt bit and the global enable both set, the selected line is asserted whatever the masks.
// - With the self-test bit set, the timer a and b output pins float and their external input pins are ignored.
// - In self-test, bit 5 replaces the external timer b input pin.
// - In self-test, bit 4 replaces the external timer a input pin.
// - Both software input bits are ignored, and the self-test counter inputs stay deasserted, while the force-interrupt bit is 0; they still read back as written.
// - Bit 3 is reserved: writes do nothing and it reads 0.
// - Flags 2, 1 and 0 set on a rising terminal count of timers c, b and a and stay set until cleared.
// - Each flag reads back its state and clears when software writes 1 to it, unless its rising terminal count arrives in the same cycle.
// - A 3-bit select field maps the interrupt onto serial lines 3, 4, 5, 10, 6, 7, 9, 11.
// - Per-timer mask bits enable each flag's contribution and a global enable gates them all.
module tis_timer_irq
    import tis_pkg::*;
(
    // Clock and reset
    input wire logic clk_sys,
    input wire logic rst,
    // AHB-Lite slave
    input wire logic hsel,
    input wire logic [31:0] haddr,
    input wire logic [1:0] htrans,
    input wire logic hwrite,
    input wire logic [2:0] hsize,
    input wire logic [31:0] hwdata,
    input wire logic hready,
    output logic hreadyout,
    output logic hresp,
    output logic [31:0] hrdata,
    // Terminal counts from the counters
    input wire logic tc_timer_a,
    input wire logic tc_timer_b,
    input wire logic tc_timer_c,
    // Timer pins
    input wire logic in_pin_timer_a,
    input wire logic in_pin_timer_b,
    output logic out_pin_timer_a,
    output logic out_pin_timer_a_oe_n,
    output logic out_pin_timer_b,
    output logic out_pin_timer_b_oe_n,
    // Input controls to the counters
    output logic timer_in_a,
    output logic timer_in_b,
    // Serial interrupt request lines, one bit per IRQ number
    output logic [15:0] irq_lines
);

    logic [7:0] test_reg;
    logic [7:0] next_test_reg;
    logic [7:0] msel_reg;
    logic [7:0] next_msel_reg;
    logic [2:0] flags;
    logic [2:0] next_flags;
    logic [2:0] tc_prev;
    logic [2:0] rise;
    logic dp_write;
    logic next_dp_write;
    logic [7:0] dp_addr;
    logic [7:0] next_dp_addr;
    logic [31:0] next_hrdata;
    logic [15:0] next_irq_lines;
    logic addr_phase;
    logic [7:0] status_view;
    logic irq_active;
    logic force_irq_test;
    logic timer_selftest_mode;
    logic sw_input_timer_a;
    logic sw_input_timer_b;
    logic timer_irq_global_enable;
    logic [2:0] irq_line_select;
    logic [2:0] mask_timers;

    assign force_irq_test = test_reg[TIS_BIT_FORCE_IRQ];
    assign timer_selftest_mode = test_reg[TIS_BIT_SELFTEST];
    assign sw_input_timer_a = test_reg[TIS_BIT_SW_IN_A];
    assign sw_input_timer_b = test_reg[TIS_BIT_SW_IN_B];
    assign timer_irq_global_enable = msel_reg[TIS_BIT_GLOBAL_EN];
    assign irq_line_select = msel_reg[TIS_SEL_LSB +: 3];
    assign mask_timers = {msel_reg[TIS_BIT_MASK_C], msel_reg[TIS_BIT_MASK_B], msel_reg[TIS_BIT_MASK_A]};

    assign hreadyout = 1'b1;
    assign hresp = TIS_HRESP_OKAY;

    // Bus address phase and read data
    assign addr_phase = hsel && hready && (htrans == TIS_HTRANS_NONSEQ || htrans == TIS_HTRANS_SEQ);
    assign status_view = {test_reg[7:4], 1'b0, flags};

    always_comb begin
        next_dp_write = addr_phase && hwrite;
        next_dp_addr = haddr[7:0];
        next_hrdata = hrdata;
        if (addr_phase && !hwrite) begin
            unique case (haddr[7:0])
                TIS_OFS_STATUS_TEST: next_hrdata = {24'h000000, status_view};
                TIS_OFS_MASK_SELECT: next_hrdata = {24'h000000, msel_reg};
                default: next_hrdata = 32'h00000000;
            endcase
        end
    end

    always_ff @(posedge clk_sys or posedge rst) begin
        if (rst) begin
            dp_write <= 1'b0;
            dp_addr <= 8'h00;
            hrdata <= 32'h00000000;
        end else begin
            dp_write <= next_dp_write;
            dp_addr <= next_dp_addr;
            hrdata <= next_hrdata;
        end
    end

    // Register writes and flag capture
    assign rise = {tc_timer_c, tc_timer_b, tc_timer_a} & ~tc_prev;

    always_comb begin
        next_test_reg = test_reg;
        next_msel_reg = msel_reg;
        next_flags = flags | rise;
        if (dp_write && dp_addr == TIS_OFS_STATUS_TEST) begin
            next_test_reg = hwdata[7:0] & TIS_TEST_WR_MASK;
            next_flags = (flags & ~hwdata[2:0]) | rise;
        end
        if (dp_write && dp_addr == TIS_OFS_MASK_SELECT) begin
            next_msel_reg = hwdata[7:0] & TIS_MSEL_WR_MASK;
        end
    end

    always_ff @(posedge clk_sys or posedge rst) begin
        if (rst) begin
            test_reg <= TIS_TEST_RESET;
            msel_reg <= TIS_MSEL_RESET;
            flags <= TIS_FLAG_RESET;
            tc_prev <= 3'h0;
        end else begin
            test_reg <= next_test_reg;
            msel_reg <= next_msel_reg;
            flags <= next_flags;
            tc_prev <= {tc_timer_c, tc_timer_b, tc_timer_a};
        end
    end

    // Pins and counter input controls
    assign out_pin_timer_a = tc_timer_a;
    assign out_pin_timer_b = tc_timer_b;
    assign out_pin_timer_a_oe_n = timer_selftest_mode;
    assign out_pin_timer_b_oe_n = timer_selftest_mode;
    assign timer_in_a = timer_selftest_mode ? (sw_input_timer_a && force_irq_test) : in_pin_timer_a;
    assign timer_in_b = timer_selftest_mode ? (sw_input_timer_b && force_irq_test) : in_pin_timer_b;

    // Interrupt routing
    assign irq_active = timer_irq_global_enable && (force_irq_test || |(flags & mask_timers));

    always_comb begin
        next_irq_lines = 16'h0000;
        next_irq_lines[TIS_IRQ_MAP[irq_line_select]] = irq_active;
    end

    always_ff @(posedge clk_sys or posedge rst) begin
        if (rst) begin
            irq_lines <= 16'h0000;
        end else begin
            irq_lines <= next_irq_lines;
        end
    end

    // Checks
    a_force_irq_line: assert property (@(posedge clk_sys) disable iff (rst)
        (force_irq_test && timer_irq_global_enable) |=> irq_lines[TIS_IRQ_MAP[$past(irq_line_select)]])
        else $error("forced interrupt not on selected line");

    a_no_irq_disabled: assert property (@(posedge clk_sys) disable iff (rst)
        !timer_irq_global_enable |=> irq_lines == 16'h0000)
        else $error("interrupt raised while globally disabled");

    a_masked_flag_quiet: assert property (@(posedge clk_sys) disable iff (rst)
        (!force_irq_test && (flags & mask_timers) == 3'h0) |=> irq_lines == 16'h0000)
        else $error("interrupt raised with no enabled flag");

    a_flag_irq_line: assert property (@(posedge clk_sys) disable iff (rst)
        (timer_irq_global_enable && irq_line_select == 3'h3 && (flags & mask_timers) != 3'h0)
        |=> irq_lines == 16'h0400)
        else $error("select code 3 not mapped to line 10");

    a_selftest_float: assert property (@(posedge clk_sys) disable iff (rst)
        timer_selftest_mode |-> (out_pin_timer_a_oe_n && out_pin_timer_b_oe_n
            && timer_in_a == (sw_input_timer_a && force_irq_test)))
        else $error("self-test pins not released");

    a_normal_pins: assert property (@(posedge clk_sys) disable iff (rst)
        !timer_selftest_mode |-> (!out_pin_timer_b_oe_n && timer_in_b == in_pin_timer_b))
        else $error("normal pins not driven");

    a_sw_in_ignored: assert property (@(posedge clk_sys) disable iff (rst)
        !force_irq_test |-> (timer_selftest_mode ? (!timer_in_a && !timer_in_b) : 1'b1))
        else $error("software input used while force bit low");

    a_rise_sets_flag: assert property (@(posedge clk_sys) disable iff (rst)
        $rose(tc_timer_c) |=> flags[TIS_BIT_FLAG_C])
        else $error("rising terminal count lost");

    a_flag_holds: assert property (@(posedge clk_sys) disable iff (rst)
        (flags[TIS_BIT_FLAG_A] && !(dp_write && dp_addr == TIS_OFS_STATUS_TEST))
        |=> flags[TIS_BIT_FLAG_A])
        else $error("flag dropped without clear");

    a_w1c_clear: assert property (@(posedge clk_sys) disable iff (rst)
        (dp_write && dp_addr == TIS_OFS_STATUS_TEST && hwdata[TIS_BIT_FLAG_B] && !rise[1])
        |=> !flags[TIS_BIT_FLAG_B])
        else $error("write one did not clear flag");

    a_reserved_zero: assert property (@(posedge clk_sys) disable iff (rst)
        ##1 $past(addr_phase && !hwrite && haddr[7:0] == TIS_OFS_STATUS_TEST) |-> !hrdata[3])
        else $error("reserved bit read as one");

endmodule // tis_timer_irq

// ---- tis_timer_irq_bench.sv ----
// Bench for the timer interrupt status and test block.
// Assumes this bench is the only AHB-Lite master.
`timescale 1ns/1ps
module tis_timer_irq_bench;
    import tis_pkg::*;
    logic clk_sys = 1'b0, rst = 1'b1, hsel = 1'b0, hwrite = 1'b0;
    logic [1:0] htrans = 2'h0, pin = 2'h0;
    logic [31:0] haddr = 32'h0, hwdata = 32'h0, rd;
    logic [2:0] tc = 3'h0;
    logic [7:0] tst = 8'h0;
    wire logic hrdy, resp, ta, tb, oa, ob, ea, eb, multi;
    wire logic [31:0] hrdata;
    wire logic [15:0] irq;
    wire logic [3:0] num;
    int seed = 87592, miscompares = 0, comparisons = 0, cycles = 0;
    tis_timer_irq u_tis_timer_irq (.clk_sys(clk_sys), .rst(rst), .hsel(hsel), .haddr(haddr),
        .htrans(htrans), .hwrite(hwrite), .hsize(3'h2), .hwdata(hwdata), .hready(hrdy),
        .hreadyout(hrdy), .hresp(resp), .hrdata(hrdata), .tc_timer_a(tc[0]), .tc_timer_b(tc[1]),
        .tc_timer_c(tc[2]), .in_pin_timer_a(pin[0]), .in_pin_timer_b(pin[1]), .out_pin_timer_a(oa),
        .out_pin_timer_a_oe_n(ea), .out_pin_timer_b(ob), .out_pin_timer_b_oe_n(eb),
        .timer_in_a(ta), .timer_in_b(tb), .irq_lines(irq));
    tis_host_model u_tis_host_model (.clk_sys(clk_sys), .rst(rst), .irq_lines(irq), .irq_num(num),
        .irq_multi(multi));
    always #5 clk_sys = ~clk_sys;
    always @(posedge clk_sys) pin <= 2'($random(seed));
    always @(posedge clk_sys) begin
        cycles <= cycles + 1;
        if (cycles == 5000) begin
            miscompares++;
            give_verdict();
        end
    end
    // Pin and counter input routing, checked every cycle
    always @(negedge clk_sys) if (!rst) chk(32'({ea, eb, ta, tb, oa, ob, resp, hrdy}), 32'({tst[6], tst[6],
        tst[6] ? tst[7] & tst[4] : pin[0], tst[6] ? tst[7] & tst[5] : pin[1], tc[0], tc[1],
        TIS_HRESP_OKAY, 1'b1}));
    function automatic logic [3:0] line_of(input logic [2:0] s);
        logic [3:0] m [8] = '{4'h3, 4'h4, 4'h5, 4'hA, 4'h6, 4'h7, 4'h9, 4'hB};
        return m[s];
    endfunction
    task automatic chk(input logic [31:0] s, input logic [31:0] e);
        comparisons++;
        if (s !== e) begin
            miscompares++;
            $display("[FAIL] %0t seen %h expected %h", $time, s, e);
        end
    endtask
    task automatic tick(input int n);
        repeat (n) @(posedge clk_sys);
    endtask
    task automatic edge_rdy();
        @(posedge clk_sys);
        while (hrdy !== 1'b1) @(posedge clk_sys);
    endtask
    task automatic xfer(input logic w, input logic [7:0] a, input logic [7:0] d, input logic rise);
        hsel <= 1'b1;
        htrans <= TIS_HTRANS_NONSEQ;
        haddr <= {24'h0, a};
        hwrite <= w;
        edge_rdy();
        hsel <= 1'b0;
        htrans <= 2'h0;
        hwdata <= {24'h0, d};
        if (rise) tc[0] <= 1'b1;
        edge_rdy();
        rd = hrdata;
        if (w && a == TIS_OFS_STATUS_TEST) tst = d & TIS_TEST_WR_MASK;
    endtask
    task automatic rchk(input logic [7:0] a, input logic [31:0] e);
        xfer(1'b0, a, 8'h00, 1'b0);
        chk(rd, e);
    endtask
    task automatic give_verdict();
        $display("comparisons %0d miscompares %0d", comparisons, miscompares);
        if (miscompares == 0 && comparisons > 0) $display("Run complete: PASS");
        else $display("Run complete: FAIL");
        $finish;
    endtask
    initial begin
        tick(20);
        rst <= 1'b0;
        tick(1);
        rchk(8'h00, 32'h0);
        rchk(8'h04, 32'h0);
        xfer(1'b1, 8'h00, 8'h08, 1'b0);
        rchk(8'h00, 32'h0);
        xfer(1'b1, 8'h04, 8'hFF, 1'b0);
        rchk(8'h04, 32'hF7);
        xfer(1'b1, 8'h08, 8'hFF, 1'b0);
        rchk(8'h08, 32'h0);
        for (int i = 0; i < 3; i++) begin
            tc[i] <= 1'b1;
            tick(2);
            tc[i] <= 1'b0;
            rchk(8'h00, 32'h1 << i);
            xfer(1'b1, 8'h00, 8'h00, 1'b0);
            rchk(8'h00, 32'h1 << i);
            chk(32'({irq, multi, num}), 32'hB | (32'h1 << 16));
            xfer(1'b1, 8'h00, 8'(1 << i), 1'b0);
            rchk(8'h00, 32'h0);
            tick(3);
            chk(32'(irq), 32'h0);
        end
        for (int s = 0; s < 8; s++) begin
            xfer(1'b1, 8'h04, 8'h82 | 8'(s << 4), 1'b0);
            tc[0] <= 1'b1;
            tick(4);
            chk(32'(irq), 32'h0);
            tc[1] <= 1'b1;
            tick(4);
            chk(32'({irq, multi, num}), {11'h0, 16'h1 << line_of(3'(s)), 1'b0, line_of(3'(s))});
            tc <= 3'h0;
            xfer(1'b1, 8'h00, 8'h03, 1'b0);
        end
        xfer(1'b1, 8'h04, 8'hD0, 1'b0);
        xfer(1'b1, 8'h00, 8'h80, 1'b0);
        tick(2);
        chk(32'(irq), 32'h80);
        xfer(1'b1, 8'h04, 8'h50, 1'b0);
        tick(2);
        chk(32'(irq), 32'h0);
        for (int m = 0; m < 16; m++) begin
            xfer(1'b1, 8'h00, 8'(m << 4), 1'b0);
            tick(5);
        end
        xfer(1'b1, 8'h00, 8'h00, 1'b0);
        tc[0] <= 1'b1;
        tick(2);
        tc[0] <= 1'b0;
        tick(1);
        xfer(1'b1, 8'h00, 8'h01, 1'b1);
        rchk(8'h00, 32'h1);
        xfer(1'b1, 8'h00, 8'h01, 1'b0);
        rchk(8'h00, 32'h0);
        rst <= 1'b1;
        tick(2);
        rst <= 1'b0;
        tick(1);
        rchk(8'h04, 32'h0);
        give_verdict();
    end
endmodule // tis_timer_irq_bench
